//--- src/psdw_pkg.sv
// package for the proximity start-delay and wait timer
package psdw_pkg;
    // register offsets on the sensor register port
    localparam logic [7:0] ADDR_START_DELAY_LOW  = 8'hEA;
    localparam logic [7:0] ADDR_START_DELAY_HIGH = 8'hEB;
    localparam logic [7:0] ADDR_WAIT_DURATION    = 8'hEC;
    localparam logic [7:0] RESET_BYTE            = 8'h00;
    localparam logic [15:0] START_DELAY_OFF      = 16'h0000;

    // timing: clock period and documented ticks, in picoseconds
    localparam longint CLK_PERIOD_PS   = 64'd8000;
    localparam longint DELAY_TICK_PS   = 64'd1357000;
    localparam longint WAIT_TICK_PS    = 64'd2779000000;
    localparam int     LONG_WAIT_MULT  = 12;
    // a tick period is neither a least nor a longest time; round to nearest
    localparam longint DELAY_TICK_CYC  = (DELAY_TICK_PS + CLK_PERIOD_PS / 2) / CLK_PERIOD_PS;
    localparam longint WAIT_TICK_CYC   = (WAIT_TICK_PS + CLK_PERIOD_PS / 2) / CLK_PERIOD_PS;

    typedef enum logic [1:0] {
        PSDW_MODE_SEQUENTIAL = 2'b00,
        PSDW_MODE_PARALLEL   = 2'b01,
        PSDW_MODE_CONCURRENT = 2'b10
    } psdw_mode_t;

    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } psdw_reg_req_t;

    typedef enum logic [1:0] {
        PSDW_ST_IDLE  = 2'b00,
        PSDW_ST_DELAY = 2'b01,
        PSDW_ST_WAIT  = 2'b10
    } psdw_state_t;
endpackage : psdw_pkg

//--- src/psdw_timer.sv
// proximity start-delay counter and proximity wait timer
// Behaviour
// - the start delay is one 16-bit value, high byte in bits 15:8 and low byte in bits 7:0.
// - the delay counts ticks of 1.357 us and a value of zero disables the delay.
// - a measurement starts only once the programmed delay has elapsed after frame sync.
// - each frame-sync pulse while integration is enabled clears and restarts the delay counter, even mid-count.
// - the wait lasts the 8-bit setting plus one, times 2.779 ms.
// - the wait is a down counter loaded at the very start of each measurement cycle.
// - a wait not longer than the measurement time is ignored.
// - with long wait on, the wait is multiplied by 12.
// - the wait applies in full parallel and concurrent modes, not in sequential mode.
module psdw_timer #(
    parameter longint DELAY_TICK_CYCLES = psdw_pkg::DELAY_TICK_CYC,
    parameter longint WAIT_TICK_CYCLES  = psdw_pkg::WAIT_TICK_CYC
) (
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    input  wire logic                    clk_en,
    input  wire psdw_pkg::psdw_reg_req_t reg_req,
    output logic [7:0]                   reg_rdata,
    input  wire logic                    frame_sync,
    input  wire logic                    integration_enable,
    input  wire psdw_pkg::psdw_mode_t    op_mode,
    input  wire logic                    prox_wait_long_multiplier,
    input  wire logic                    meas_done,
    output logic                         meas_start,
    output logic                         wait_active
);
    logic [7:0]  prox_start_delay_low_byte;
    logic [7:0]  prox_start_delay_high_byte;
    logic [7:0]  prox_wait_duration;
    logic [7:0]  next_low;
    logic [7:0]  next_high;
    logic [7:0]  next_wait_dur;
    logic [7:0]  next_rdata;
    logic [2:0]  sync_q;
    logic [2:0]  next_sync_q;
    psdw_pkg::psdw_state_t state;
    psdw_pkg::psdw_state_t next_state;
    logic [31:0] tick_cnt;
    logic [31:0] next_tick_cnt;
    logic [15:0] delay_cnt;
    logic [15:0] next_delay_cnt;
    logic [12:0] wait_cnt;
    logic [12:0] next_wait_cnt;
    logic        next_meas_start;
    logic [15:0] prox_start_delay;
    logic        sync_pulse;
    logic        wait_applies;

    localparam logic [31:0] DTICK = 32'(DELAY_TICK_CYCLES - 1);
    localparam logic [31:0] WTICK = 32'(WAIT_TICK_CYCLES - 1);
    localparam logic [15:0] START_DELAY_ZERO = psdw_pkg::START_DELAY_OFF;

    assign prox_start_delay = {prox_start_delay_high_byte, prox_start_delay_low_byte};
    // sync_q[0] feeds only sync_q[1]; edge seen between stages 1 and 2
    assign sync_pulse       = sync_q[1] & ~sync_q[2];
    assign wait_applies     = (op_mode == psdw_pkg::PSDW_MODE_PARALLEL) ||
                              (op_mode == psdw_pkg::PSDW_MODE_CONCURRENT);
    assign wait_active      = (state == psdw_pkg::PSDW_ST_WAIT);

    always_comb begin
        next_low      = prox_start_delay_low_byte;
        next_high     = prox_start_delay_high_byte;
        next_wait_dur = prox_wait_duration;
        next_rdata    = reg_rdata;
        if (reg_req.wr) begin
            if (reg_req.addr == psdw_pkg::ADDR_START_DELAY_LOW) begin
                next_low = reg_req.wdata;
            end else if (reg_req.addr == psdw_pkg::ADDR_START_DELAY_HIGH) begin
                next_high = reg_req.wdata;
            end else if (reg_req.addr == psdw_pkg::ADDR_WAIT_DURATION) begin
                next_wait_dur = reg_req.wdata;
            end
        end else begin
            if (reg_req.addr == psdw_pkg::ADDR_START_DELAY_LOW) begin
                next_rdata = prox_start_delay_low_byte;
            end else if (reg_req.addr == psdw_pkg::ADDR_START_DELAY_HIGH) begin
                next_rdata = prox_start_delay_high_byte;
            end else if (reg_req.addr == psdw_pkg::ADDR_WAIT_DURATION) begin
                next_rdata = prox_wait_duration;
            end else begin
                next_rdata = psdw_pkg::RESET_BYTE;
            end
        end
    end

    always_comb begin
        next_sync_q     = {sync_q[1:0], frame_sync};
        next_state      = state;
        next_tick_cnt   = tick_cnt;
        next_delay_cnt  = delay_cnt;
        next_wait_cnt   = wait_cnt;
        next_meas_start = 1'b0;
        case (state)
            psdw_pkg::PSDW_ST_IDLE: begin
            end
            psdw_pkg::PSDW_ST_DELAY: begin
                if (delay_cnt == prox_start_delay) begin
                    next_meas_start = 1'b1;
                    next_tick_cnt   = '0;
                    // wait counts from cycle start, covering initialisation
                    next_wait_cnt   = prox_wait_long_multiplier ?
                        13'((prox_wait_duration + 13'd1) * 13'(psdw_pkg::LONG_WAIT_MULT)) :
                        13'(prox_wait_duration + 13'd1);
                    next_state      = wait_applies ? psdw_pkg::PSDW_ST_WAIT :
                                                     psdw_pkg::PSDW_ST_IDLE;
                end else if (tick_cnt == DTICK) begin
                    next_tick_cnt  = '0;
                    next_delay_cnt = delay_cnt + 16'h0001;
                end else begin
                    next_tick_cnt = tick_cnt + 32'h0000_0001;
                end
            end
            psdw_pkg::PSDW_ST_WAIT: begin
                // wait ending before the measurement counts as ignored
                if (wait_cnt == 13'h0000 && meas_done) begin
                    next_state = psdw_pkg::PSDW_ST_IDLE;
                end else if (wait_cnt != 13'h0000) begin
                    if (tick_cnt == WTICK) begin
                        next_tick_cnt = '0;
                        next_wait_cnt = wait_cnt - 13'h0001;
                    end else begin
                        next_tick_cnt = tick_cnt + 32'h0000_0001;
                    end
                end
            end
            default: next_state = psdw_pkg::PSDW_ST_IDLE;
        endcase
        // frame sync restarts the delay from zero in any state
        if (sync_pulse && integration_enable) begin
            next_state     = psdw_pkg::PSDW_ST_DELAY;
            next_tick_cnt  = '0;
            next_delay_cnt = START_DELAY_ZERO;
        end
        // stopping integration also suppresses a start that was about to fire
        if (!integration_enable) begin
            next_state      = psdw_pkg::PSDW_ST_IDLE;
            next_meas_start = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            prox_start_delay_low_byte  <= psdw_pkg::RESET_BYTE;
            prox_start_delay_high_byte <= psdw_pkg::RESET_BYTE;
            prox_wait_duration         <= psdw_pkg::RESET_BYTE;
            reg_rdata                  <= psdw_pkg::RESET_BYTE;
            sync_q                     <= 3'h0;
            state                      <= psdw_pkg::PSDW_ST_IDLE;
            tick_cnt                   <= 32'h0000_0000;
            delay_cnt                  <= 16'h0000;
            wait_cnt                   <= 13'h0000;
            meas_start                 <= 1'b0;
        end else if (clk_en) begin
            prox_start_delay_low_byte  <= next_low;
            prox_start_delay_high_byte <= next_high;
            prox_wait_duration         <= next_wait_dur;
            reg_rdata                  <= next_rdata;
            sync_q                     <= next_sync_q;
            state                      <= next_state;
            tick_cnt                   <= next_tick_cnt;
            delay_cnt                  <= next_delay_cnt;
            wait_cnt                   <= next_wait_cnt;
            meas_start                 <= next_meas_start;
        end
    end
endmodule : psdw_timer

//--- tb/psdw_sync_model.sv
// display driver model issuing frame-sync pulses on request
module psdw_sync_model (
    input  wire logic clk,
    input  wire logic fire,
    output logic      frame_sync
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] cnt = 3'h0;
    // pulse spans several cycles so the two-flop synchroniser cannot miss it
    always_ff @(posedge clk) begin
        if (fire) begin
            cnt <= 3'h4;
        end else if (cnt != 3'h0) begin
            cnt <= cnt - 3'h1;
        end
    end
    assign frame_sync = (cnt != 3'h0);
endmodule : psdw_sync_model

//--- tb/psdw_timer_properties.sv
// assertions on the timer ports
module psdw_timer_properties #(
    parameter longint DELAY_TICK_CYCLES = 4,
    parameter longint WAIT_TICK_CYCLES  = 8
) (
    input wire logic                    clk,
    input wire logic                    reset_n,
    input wire logic                    clk_en,
    input wire psdw_pkg::psdw_reg_req_t reg_req,
    input wire logic [7:0]              reg_rdata,
    input wire logic                    frame_sync,
    input wire logic                    integration_enable,
    input wire psdw_pkg::psdw_mode_t    op_mode,
    input wire logic                    prox_wait_long_multiplier,
    input wire logic                    meas_done,
    input wire logic                    meas_start,
    input wire logic                    wait_active
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // holds only while a wait tick is at least five cycles long
    sequence s_wait_run; wait_active [*6]; endsequence
    sequence s_seq_start; meas_start && op_mode == psdw_pkg::PSDW_MODE_SEQUENTIAL; endsequence
    AST_PULSE: assert property (meas_start |=> !meas_start)
        else $error("start pulse longer than one cycle");
    AST_IDLE_OFF: assert property (!integration_enable [*2] |-> !meas_start && !wait_active)
        else $error("activity while integration stopped");
    AST_SEQ: assert property (s_seq_start |=> !wait_active)
        else $error("wait applied in sequential mode");
    AST_PAR: assert property (meas_start && op_mode != psdw_pkg::PSDW_MODE_SEQUENTIAL
        |-> ##[0:1] wait_active)
        else $error("wait not started with measurement");
    AST_WAIT_MIN: assert property ($rose(wait_active) |-> s_wait_run)
        else $error("wait shorter than one tick");
    AST_UNMAP: assert property (clk_en && !reg_req.wr && !(reg_req.addr inside
        {[psdw_pkg::ADDR_START_DELAY_LOW:psdw_pkg::ADDR_WAIT_DURATION]})
        |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_RST: assert property ($rose(reset_n) |-> !meas_start && !wait_active)
        else $error("outputs not cleared by reset");
    AST_FREEZE: assert property (!clk_en |=> $stable(wait_active) && $stable(meas_start))
        else $error("state moved with clock enable low");
endmodule : psdw_timer_properties
bind psdw_timer psdw_timer_properties #(.DELAY_TICK_CYCLES(DELAY_TICK_CYCLES),
    .WAIT_TICK_CYCLES(WAIT_TICK_CYCLES)) u_psdw_timer_properties (.clk(clk),
    .reset_n(reset_n), .clk_en(clk_en), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .frame_sync(frame_sync), .integration_enable(integration_enable), .op_mode(op_mode),
    .prox_wait_long_multiplier(prox_wait_long_multiplier), .meas_done(meas_done),
    .meas_start(meas_start), .wait_active(wait_active));

//--- tb/psdw_timer_tb.sv
// testbench for the start-delay and wait timer
module psdw_timer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                    clk, reset_n, clk_en, fire, frame_sync, integ_en, lmul, mstart, wact;
    logic [7:0]              rdata;
    psdw_pkg::psdw_reg_req_t req;
    psdw_pkg::psdw_mode_t    mode;
    int                      num_errors, n_tests, c;
    logic [15:0]             dl [3] = '{16'h0003, 16'h0100, 16'h0000};
    psdw_pkg::psdw_mode_t    md [3] = '{psdw_pkg::PSDW_MODE_PARALLEL,
        psdw_pkg::PSDW_MODE_CONCURRENT, psdw_pkg::PSDW_MODE_SEQUENTIAL};
    int                      lo [3] = '{20, 282, 1};
    int                      hi [3] = '{28, 292, 2};
    psdw_timer #(.DELAY_TICK_CYCLES(4), .WAIT_TICK_CYCLES(8)) u_psdw_timer (.clk(clk),
        .reset_n(reset_n), .clk_en(clk_en), .reg_req(req), .reg_rdata(rdata),
        .frame_sync(frame_sync), .integration_enable(integ_en), .op_mode(mode),
        .prox_wait_long_multiplier(lmul), .meas_done(1'b1), .meas_start(mstart),
        .wait_active(wact));
    psdw_sync_model u_psdw_sync_model (.clk(clk), .fire(fire), .frame_sync(frame_sync));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task print_verdict;
        $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : print_verdict
    task chk(input logic [31:0] got, input int l, input int h);
        n_tests++;
        if ((got >= l && got <= h) !== 1'b1) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h..%h", $time, got, l, h);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) req <= '{1'b1, a, d};
        @(posedge clk) req <= '0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk) req <= '{1'b0, a, 8'h00};
        @(posedge clk) req <= '0;
        @(negedge clk) chk({24'h0, rdata}, e, e);
    endtask : rd
    task sync;
        @(posedge clk) fire <= 1'b1;
        @(posedge clk) fire <= 1'b0;
    endtask : sync
    task meas(output int n);
        n = 0;
        while (mstart !== 1'b1) begin
            @(negedge clk) n++;
            if (n > 3000) begin
                num_errors++;
                print_verdict();
            end
        end
    endtask : meas
    task run_wait(output int n);
        n = 0;
        do @(negedge clk) n++; while (wact === 1'b1 && n < 5000);
    endtask : run_wait
    initial begin
        reset_n = 0; clk_en = 0; fire = 0; integ_en = 0; lmul = 0; req = '0;
        mode = psdw_pkg::PSDW_MODE_PARALLEL;
        num_errors = 0;
        n_tests = 0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk);
        clk_en <= 1'b1;
        rd(psdw_pkg::ADDR_START_DELAY_LOW, 8'h00);
        rd(psdw_pkg::ADDR_START_DELAY_HIGH, 8'h00);
        rd(psdw_pkg::ADDR_WAIT_DURATION, 8'h00);
        wr(8'hED, 8'h5A);
        rd(8'hED, 8'h00);
        wr(psdw_pkg::ADDR_WAIT_DURATION, 8'h02);
        rd(psdw_pkg::ADDR_WAIT_DURATION, 8'h02);
        @(posedge clk) integ_en <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            wr(psdw_pkg::ADDR_START_DELAY_HIGH, dl[i][15:8]);
            wr(psdw_pkg::ADDR_START_DELAY_LOW, dl[i][7:0]);
            sync();
            meas(c);
            chk(c, 4 * dl[i], 4 * dl[i] + 8);
            run_wait(c);
        end
        for (int i = 0; i < 3; i++) begin
            @(posedge clk) mode <= md[i];
            lmul <= (i == 1);
            sync();
            meas(c);
            run_wait(c);
            chk(c, lo[i], hi[i]);
        end
        // second pulse lands mid-count; delay outlasts the pulse spacing
        wr(psdw_pkg::ADDR_START_DELAY_LOW, 8'h10);
        sync();
        repeat (30) @(posedge clk);
        sync();
        meas(c);
        chk(c, 64, 72);
        // host stops integration, then pulses frame sync once; frame sync must be ignored
        @(posedge clk) integ_en <= 1'b0;
        sync();
        c = 0;
        repeat (90) @(negedge clk) c += (mstart !== 1'b0);
        chk(c, 0, 0);
        print_verdict();
    end
endmodule : psdw_timer_tb
